// ===== core/anpr_pkg.sv
// Constants for the autonegotiation page register block.
// Assumes a 32-bit APB slave; each register is one aligned word at four times its index.
package anpr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_PEER_LOW = 14'h0205;
	localparam logic [13:0] IDX_PEER_HIGH = 14'h0207;
	localparam logic [13:0] IDX_NP_LOW = 14'h0208;
	localparam logic [13:0] IDX_NP_MID = 14'h0209;
	localparam logic [13:0] IDX_NP_HIGH = 14'h020a;
	localparam logic [13:0] IDX_CTRL = 14'h0210;
	localparam logic [13:0] IDX_STAT = 14'h0211;
	// Reset values
	localparam logic [15:0] PEER_HIGH_RST = 16'h0000;
	localparam logic [15:0] NP_LOW_RST = 16'h2001;
	localparam logic [15:0] NP_MID_RST = 16'h0000;
	localparam logic [15:0] NP_HIGH_RST = 16'h0000;
	// Partner base page upper word fields
	localparam int PEER_EEE = 14;
	localparam int PEER_HI_ABLE = 13;
	localparam int PEER_HI_REQ = 12;
	localparam int PEER_SR_HD = 11;
	localparam logic [15:0] PEER_HIGH_MASK = 16'h7800;
	// Next page low word fields
	localparam int NP_MORE = 15;
	localparam int NP_ACK = 14;
	localparam int NP_MSG = 13;
	localparam int NP_COMPLY = 12;
	localparam int NP_TOGGLE = 11;
	localparam int CODE_W = 11;
	// Message codes
	localparam logic [10:0] CODE_NULL = 11'h001;
	localparam logic [10:0] CODE_OUI = 11'h005;
	localparam logic [10:0] CODE_DEVID = 11'h006;
	// Control and status fields
	localparam int CTRL_AN_RESET = 0;
	localparam int STAT_PENDING = 0;
	localparam int STAT_TOGGLE = 1;
	localparam int STAT_HI_LEVEL = 2;
	localparam int STAT_CODE_KNOWN = 3;
	localparam int PAGE_W = 48;
endpackage

// ===== core/anpr_page_if.sv
// Carrier between register logic and next page sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface anpr_page_if;
	logic commit;
	logic [47:0] page;
	logic pending;
	logic toggle;
	modport mgr (output commit, output page, input pending, input toggle);
	modport seq (input commit, input page, output pending, output toggle);
endinterface

// ===== core/anpr_page_seq.sv
// Next page sequencer: holds the committed page, inserts the toggle bit.
// Assumes the transmitter takes a page on txValid and txReady both high.
`timescale 1ns/1ps
module anpr_page_seq (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic anReset,
	input wire logic baseSent,
	input wire logic baseToggle,
	input wire logic txReady,
	anpr_page_if.seq pg,
	output logic txValid,
	output logic [47:0] txPage
);
	typedef enum logic {SEQ_IDLE, SEQ_OFFER} anpr_seq_state_type;
	anpr_seq_state_type state_ff;
	logic toggle_ff;
	logic nxt_toggle;
	logic [47:0] page_ff;
	logic txToggle_ff;
	logic handshake;

	assign handshake = (state_ff == SEQ_OFFER) && txReady;

	always_comb begin
		nxt_toggle = toggle_ff;
		if (anReset) begin
			nxt_toggle = 1'b0;
		end else if (baseSent) begin
			nxt_toggle = ~baseToggle;
		end else if (handshake) begin
			nxt_toggle = ~toggle_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			toggle_ff <= 1'b0;
			txToggle_ff <= 1'b0;
		end else begin
			toggle_ff <= nxt_toggle;
			txToggle_ff <= nxt_toggle;
		end
	end

	// New commit replaces a page still on offer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= SEQ_IDLE;
			page_ff <= '0;
		end else if (anReset) begin
			state_ff <= SEQ_IDLE;
		end else if (pg.commit) begin
			state_ff <= SEQ_OFFER;
			page_ff <= pg.page;
		end else if (handshake) begin
			state_ff <= SEQ_IDLE;
		end
	end

	assign txValid = (state_ff == SEQ_OFFER);
	assign txPage = {page_ff[47:12], txToggle_ff, page_ff[10:0]};
	assign pg.pending = txValid;
	assign pg.toggle = toggle_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	chk_toggle_flip: assert property (
		handshake && !baseSent && !anReset |=> toggle_ff == !$past(toggle_ff))
		else $error("toggle did not invert after a page was sent");
	chk_atomic_commit: assert property (
		pg.commit && !anReset |=> txValid && txPage[47:12] == $past(pg.page[47:12])
			&& txPage[10:0] == $past(pg.page[10:0]))
		else $error("committed page not offered whole");
	chk_offer_stable: assert property (
		txValid && !txReady && !pg.commit && !anReset && !baseSent |=> txValid && $stable(txPage))
		else $error("offered page changed before it was taken");
endmodule

// ===== core/anpr_page_regs.sv
// Autonegotiation page registers: partner base page upper word snapshot
// and next page transmit words, reached over APB.
// Assumes partner page words and transmitter handshake come from logic on clk_sys.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// How it works
// - Partner upper word is captured only when the partner lowest word is read.
// - Reads of the partner upper word return the captured snapshot.
// - Partner upper word resets to zero and ignores writes.
// - Bit 14 shows partner long-reach energy-saving ability.
// - Bit 12 shows partner request for high-amplitude transmit level.
// - Bit 11 shows partner short-reach half duplex; bit 13 shows partner high-level ability; other bits read zero.
// - Reset and autoneg reset load next page low word with null message page.
// - Bit 15 requests another next page; writable, resets to zero.
// - Bit 14 is acknowledge; read-only, resets to zero.
// - Bit 13 selects message or unformatted page; writable, resets to one.
// - Bit 12 is the can-comply flag; writable, resets to zero.
// - Bit 11 reads zero; the sequencer inserts the real toggle.
// - Bits 10 to 0 are the writable code field, reset to one.
// - Message codes: 1 null, 5 tagged identifier, 6 device identifier tag.
// - Middle word is a writable 16-bit field resetting to zero.
module anpr_page_regs (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [15:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] peerPageLow,
	input wire logic [15:0] peerPageHigh,
	input wire logic linkAck,
	input wire logic localHighAmplitudeRequest,
	input wire logic baseSent,
	input wire logic baseToggle,
	input wire logic txReady,
	output logic txValid,
	output logic [47:0] txPage,
	output logic highLevelSelect
);
	anpr_page_if pg ();

	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [15:0] peerHigh_ff;
	logic moreReq_ff;
	logic isMessage_ff;
	logic canComply_ff;
	logic [10:0] pageCode_ff;
	logic [15:0] npMid_ff;
	logic [15:0] npHigh_ff;
	logic ack_ff;
	logic anReset_ff;
	logic commit_ff;
	logic highLevel_ff;

	logic setup;
	logic accessEdge;
	logic wrEdge;
	logic rdEdge;
	logic aligned;
	logic [13:0] wordIdx;
	logic hitPeerLow;
	logic hitPeerHigh;
	logic hitNpLow;
	logic hitNpMid;
	logic hitNpHigh;
	logic hitCtrl;
	logic hitStat;
	logic hitAny;
	logic [15:0] npLowWord;
	logic codeKnown;
	logic [15:0] readWord;

	// Bus phase decode
	assign setup = psel && !penable;
	assign accessEdge = psel && penable && pready_ff;
	assign wrEdge = accessEdge && pwrite;
	assign rdEdge = accessEdge && !pwrite;

	// Address decode on whole aligned words
	assign aligned = (paddr[1:0] == 2'h0);
	assign wordIdx = paddr[15:2];
	assign hitPeerLow = aligned && (wordIdx == anpr_pkg::IDX_PEER_LOW);
	assign hitPeerHigh = aligned && (wordIdx == anpr_pkg::IDX_PEER_HIGH);
	assign hitNpLow = aligned && (wordIdx == anpr_pkg::IDX_NP_LOW);
	assign hitNpMid = aligned && (wordIdx == anpr_pkg::IDX_NP_MID);
	assign hitNpHigh = aligned && (wordIdx == anpr_pkg::IDX_NP_HIGH);
	assign hitCtrl = aligned && (wordIdx == anpr_pkg::IDX_CTRL);
	assign hitStat = aligned && (wordIdx == anpr_pkg::IDX_STAT);
	assign hitAny = hitPeerLow || hitPeerHigh || hitNpLow || hitNpMid
		|| hitNpHigh || hitCtrl || hitStat;

	// Low word as software sees it; toggle and acknowledge positions filled here
	always_comb begin
		npLowWord = '0;
		npLowWord[anpr_pkg::NP_MORE] = moreReq_ff;
		npLowWord[anpr_pkg::NP_ACK] = ack_ff;
		npLowWord[anpr_pkg::NP_MSG] = isMessage_ff;
		npLowWord[anpr_pkg::NP_COMPLY] = canComply_ff;
		npLowWord[anpr_pkg::NP_TOGGLE] = 1'b0;
		npLowWord[10:0] = pageCode_ff;
	end

	// Message page carrying a code that the receiver understands
	assign codeKnown = isMessage_ff && ((pageCode_ff == anpr_pkg::CODE_NULL)
		|| (pageCode_ff == anpr_pkg::CODE_OUI)
		|| (pageCode_ff == anpr_pkg::CODE_DEVID));

	// Read multiplexer
	always_comb begin
		readWord = '0;
		if (hitPeerLow) begin
			readWord = peerPageLow;
		end else if (hitPeerHigh) begin
			readWord = peerHigh_ff;
		end else if (hitNpLow) begin
			readWord = npLowWord;
		end else if (hitNpMid) begin
			readWord = npMid_ff;
		end else if (hitNpHigh) begin
			readWord = npHigh_ff;
		end else if (hitStat) begin
			readWord[anpr_pkg::STAT_PENDING] = pg.pending;
			readWord[anpr_pkg::STAT_TOGGLE] = pg.toggle;
			readWord[anpr_pkg::STAT_HI_LEVEL] = highLevel_ff;
			readWord[anpr_pkg::STAT_CODE_KNOWN] = codeKnown;
		end
	end

	// Answer in the first access cycle: ready, data and error all registered
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !hitAny;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata_ff <= '0;
		end else if (setup) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : {16'h0000, readWord};
		end
	end

	// Autonegotiation reset: one-cycle pulse from a control write
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			anReset_ff <= 1'b0;
		end else begin
			anReset_ff <= wrEdge && hitCtrl && pwdata[anpr_pkg::CTRL_AN_RESET];
		end
	end

	// Partner upper word snapshot, taken only by a read of the lowest word
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			peerHigh_ff <= anpr_pkg::PEER_HIGH_RST;
		end else if (anReset_ff) begin
			peerHigh_ff <= anpr_pkg::PEER_HIGH_RST;
		end else if (rdEdge && hitPeerLow) begin
			peerHigh_ff <= peerPageHigh & anpr_pkg::PEER_HIGH_MASK;
		end
	end

	// Transmit level: partner able and either end asks for it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			highLevel_ff <= 1'b0;
		end else begin
			highLevel_ff <= peerHigh_ff[anpr_pkg::PEER_HI_ABLE]
				&& (peerHigh_ff[anpr_pkg::PEER_HI_REQ] || localHighAmplitudeRequest);
		end
	end

	// Next page low word fields
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			moreReq_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_MORE];
			isMessage_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_MSG];
			canComply_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_COMPLY];
			pageCode_ff <= anpr_pkg::NP_LOW_RST[10:0];
		end else if (anReset_ff) begin
			moreReq_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_MORE];
			isMessage_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_MSG];
			canComply_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_COMPLY];
			pageCode_ff <= anpr_pkg::NP_LOW_RST[10:0];
		end else if (wrEdge && hitNpLow) begin
			moreReq_ff <= pwdata[anpr_pkg::NP_MORE];
			isMessage_ff <= pwdata[anpr_pkg::NP_MSG];
			canComply_ff <= pwdata[anpr_pkg::NP_COMPLY];
			pageCode_ff <= pwdata[10:0];
		end
	end

	// Acknowledge follows the arbitration logic, never the bus
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_ACK];
		end else if (anReset_ff) begin
			ack_ff <= anpr_pkg::NP_LOW_RST[anpr_pkg::NP_ACK];
		end else begin
			ack_ff <= linkAck;
		end
	end

	// Middle and high words; staged until the low word completes the page
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			npMid_ff <= anpr_pkg::NP_MID_RST;
		end else if (anReset_ff) begin
			npMid_ff <= anpr_pkg::NP_MID_RST;
		end else if (wrEdge && hitNpMid) begin
			npMid_ff <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			npHigh_ff <= anpr_pkg::NP_HIGH_RST;
		end else if (anReset_ff) begin
			npHigh_ff <= anpr_pkg::NP_HIGH_RST;
		end else if (wrEdge && hitNpHigh) begin
			npHigh_ff <= pwdata[15:0];
		end
	end

	// Commit one cycle after the low word write, when all fields are settled
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			commit_ff <= 1'b0;
		end else begin
			commit_ff <= wrEdge && hitNpLow && !anReset_ff;
		end
	end

	assign pg.commit = commit_ff;
	assign pg.page = {npHigh_ff, npMid_ff, npLowWord};

	anpr_page_seq u_seq (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.anReset(anReset_ff),
		.baseSent(baseSent),
		.baseToggle(baseToggle),
		.txReady(txReady),
		.pg(pg.seq),
		.txValid(txValid),
		.txPage(txPage)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign highLevelSelect = highLevel_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	chk_snapshot_take: assert property (
		rdEdge && hitPeerLow && !anReset_ff
			|=> peerHigh_ff == ($past(peerPageHigh) & anpr_pkg::PEER_HIGH_MASK))
		else $error("upper word not captured on lowest word read");
	chk_snapshot_hold: assert property (
		!(rdEdge && hitPeerLow) && !anReset_ff |=> $stable(peerHigh_ff))
		else $error("upper word snapshot changed without a capture");
	chk_peer_read: assert property (
		setup && !pwrite && hitPeerHigh |=> prdata_ff == {16'h0000, $past(peerHigh_ff)})
		else $error("upper word read did not return snapshot");
	chk_reserved_zero: assert property (
		(peerHigh_ff & ~anpr_pkg::PEER_HIGH_MASK) == 16'h0000)
		else $error("reserved partner bits not zero");
	chk_np_default: assert property (
		anReset_ff |=> npLowWord[15:12] == anpr_pkg::NP_LOW_RST[15:12] && pageCode_ff == 11'h001
			&& npMid_ff == 16'h0000 && npHigh_ff == 16'h0000)
		else $error("autoneg reset did not restore next page defaults");
	chk_fields_write: assert property (
		wrEdge && hitNpLow && !anReset_ff |=> moreReq_ff == $past(pwdata[15])
			&& isMessage_ff == $past(pwdata[13]) && canComply_ff == $past(pwdata[12])
			&& pageCode_ff == $past(pwdata[10:0]))
		else $error("low word writable fields not stored");
	chk_ack_readonly: assert property (
		!anReset_ff |=> ack_ff == $past(linkAck))
		else $error("acknowledge bit not following arbitration");
	chk_toggle_reads0: assert property (
		setup && !pwrite && hitNpLow |=> prdata_ff[11] == 1'b0 && pready_ff)
		else $error("toggle bit read as one");
	chk_mid_write: assert property (
		wrEdge && hitNpMid && !anReset_ff |=> npMid_ff == $past(pwdata[15:0]))
		else $error("middle word not written");
	chk_commit_pulse: assert property (
		wrEdge && hitNpLow && !anReset_ff |=> commit_ff ##1 !commit_ff || (wrEdge && hitNpLow))
		else $error("low word write did not commit the page");
	chk_level_pick: assert property (
		peerHigh_ff[13] && peerHigh_ff[12] |=> highLevel_ff)
		else $error("high level not chosen when partner able and asking");
	chk_ready_once: assert property (
		pready_ff |=> !pready_ff)
		else $error("ready held beyond one access cycle");

	// Every access is answered at once; unmapped ones carry the error
	chk_ready_answer: assert property (
		setup |=> pready_ff && (pslverr_ff == !$past(hitAny)))
		else $error("bus access not answered in its first access cycle");
	chk_write_rdata: assert property (
		setup && pwrite |=> prdata_ff == 32'h0000_0000)
		else $error("read data not zero on a write");
	// Read-only snapshot and its clearing
	chk_ro_ignore: assert property (
		wrEdge && hitPeerHigh && !anReset_ff |=> $stable(peerHigh_ff))
		else $error("partner upper word took a write");
	chk_snapshot_clear: assert property (
		anReset_ff |=> peerHigh_ff == anpr_pkg::PEER_HIGH_RST)
		else $error("autoneg reset did not clear the snapshot");
	// Transmit level needs partner ability
	chk_level_unable: assert property (
		!peerHigh_ff[anpr_pkg::PEER_HI_ABLE] |=> !highLevel_ff)
		else $error("high level chosen though partner unable");
	chk_level_local: assert property (
		peerHigh_ff[anpr_pkg::PEER_HI_ABLE] && localHighAmplitudeRequest |=> highLevel_ff)
		else $error("high level not chosen on local request");
	chk_ack_reset: assert property (
		anReset_ff |=> !ack_ff)
		else $error("acknowledge not cleared by autoneg reset");
	chk_high_write: assert property (
		wrEdge && hitNpHigh && !anReset_ff |=> npHigh_ff == $past(pwdata[15:0]))
		else $error("high word not written");
	chk_commit_only: assert property (
		!(wrEdge && hitNpLow && !anReset_ff) |=> !commit_ff)
		else $error("page committed without a low word write");
	chk_ctrl_pulse: assert property (
		anReset_ff |=> !anReset_ff)
		else $error("autoneg reset longer than one cycle");
endmodule

// ===== testbench/anpr_partner_model.sv
// Link partner model: supplies partner page words, acknowledge and base page events,
// and takes offered next pages unless told to stall.
// Assumes it shares clk_sys with the register block.
`timescale 1ns/1ps
module anpr_partner_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic txValid,
	input wire logic [47:0] txPage,
	output logic [15:0] peerPageLow,
	output logic [15:0] peerPageHigh,
	output logic linkAck,
	output logic baseSent,
	output logic baseToggle,
	output logic txReady
);
	logic stall = 1'b0;
	logic [47:0] lastPage = 48'h0;
	initial begin
		peerPageHigh = 16'h0000;
		linkAck = 1'b0;
		baseSent = 1'b0;
		baseToggle = 1'b0;
	end
	// Live low word keeps moving so a stale capture shows up
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			peerPageLow <= 16'h0000;
			txReady <= 1'b0;
		end else begin
			peerPageLow <= peerPageLow + 16'h0001;
			txReady <= !stall;
		end
	end
	always @(posedge clk_sys) begin
		if (txValid && txReady) begin
			lastPage <= txPage;
		end
	end
	task automatic setPeer(input logic [15:0] h, input logic ack);
		@(posedge clk_sys);
		peerPageHigh <= h;
		linkAck <= ack;
	endtask
	task automatic sendBase(input logic tog);
		@(posedge clk_sys);
		baseSent <= 1'b1;
		baseToggle <= tog;
		@(posedge clk_sys);
		baseSent <= 1'b0;
		// Toggle is only valid with the pulse
		baseToggle <= !tog;
	endtask
endmodule

// ===== testbench/autoneg_page_registers_bench.sv
// Self-checking bench for the autonegotiation page registers over APB.
// Assumes one 100 MHz clock and the partner model on the far side.
`timescale 1ns/1ps
module autoneg_page_registers_bench;
	typedef struct {logic wr; logic [15:0] addr; logic [15:0] data;} anpr_row_type;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, linkAck, baseSent, baseToggle, txReady, txValid, highLevelSelect;
	logic [15:0] peerPageLow, peerPageHigh;
	logic localHighAmplitudeRequest = 1'b0;
	logic [47:0] txPage, rd, expPage;
	logic err, tog;
	int fail_count = 0;
	int n_compared = 0;
	logic [10:0] codes[4] = '{anpr_pkg::CODE_NULL, anpr_pkg::CODE_OUI, anpr_pkg::CODE_DEVID,
		11'h007};
	anpr_row_type rows[12] = '{
		'{1'b0, 16'h081c, 16'h0000}, '{1'b0, 16'h0820, 16'h2001},
		'{1'b0, 16'h0824, 16'h0000}, '{1'b0, 16'h0828, 16'h0000},
		'{1'b1, 16'h081c, 16'hffff}, '{1'b0, 16'h081c, 16'h0000},
		'{1'b1, 16'h0824, 16'ha5c3}, '{1'b0, 16'h0824, 16'ha5c3},
		'{1'b1, 16'h0820, 16'hffff}, '{1'b0, 16'h0820, 16'hb7ff},
		'{1'b1, 16'h0820, 16'h0000}, '{1'b0, 16'h0820, 16'h0000}};

	anpr_page_regs anpr_page_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .peerPageLow(peerPageLow),
		.peerPageHigh(peerPageHigh), .linkAck(linkAck),
		.localHighAmplitudeRequest(localHighAmplitudeRequest), .baseSent(baseSent),
		.baseToggle(baseToggle), .txReady(txReady), .txValid(txValid), .txPage(txPage),
		.highLevelSelect(highLevelSelect));
	anpr_partner_model partner_i (.clk_sys(clk_sys), .rst_b(rst_b), .txValid(txValid),
		.txPage(txPage), .peerPageLow(peerPageLow), .peerPageHigh(peerPageHigh),
		.linkAck(linkAck), .baseSent(baseSent), .baseToggle(baseToggle), .txReady(txReady));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s", $time, msg);
			fail_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {16'h0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		rd = {16'h0000, prdata};
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({47'h0, n == 1}, 48'h1, "bus answer not in first access cycle");
	endtask
	task automatic waitTx(input logic lvl);
		int n;
		n = 0;
		while (txValid !== lvl && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		chk({47'h0, txValid}, {47'h0, lvl}, "page offer level");
	endtask
	task automatic test_done();
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			apb(rows[i].wr, rows[i].addr, rows[i].data);
			chk({47'h0, err}, 48'h0, "error on mapped register");
			if (!rows[i].wr) begin
				chk(rd, {32'h0, rows[i].data}, "register read");
			end
		end
		apb(1'b0, 16'h0900, 16'h0000);
		chk({47'h0, err}, 48'h1, "unmapped access");
		apb(1'b0, 16'h0822, 16'h0000);
		chk({47'h0, err}, 48'h1, "misaligned access");
		partner_i.setPeer(16'hffff, 1'b0);
		apb(1'b0, 16'h081c, 16'h0000);
		chk(rd, 48'h0, "snapshot before capture");
		for (int b = 11; b < 16; b++) begin
			partner_i.setPeer(16'h87ff | (16'h0001 << b), 1'b0);
			apb(1'b0, 16'h0814, 16'h0000);
			partner_i.setPeer(16'h0000, 1'b0);
			apb(1'b0, 16'h081c, 16'h0000);
			chk(rd, {32'h0, 16'h7800 & (16'h0001 << b)}, "partner upper word");
		end
		for (int k = 0; k < 4; k++) begin
			partner_i.setPeer(k < 2 ? 16'h2000 : (k == 2 ? 16'h3000 : 16'h1000), 1'b0);
			localHighAmplitudeRequest <= k[0];
			apb(1'b0, 16'h0814, 16'h0000);
			repeat (2) @(posedge clk_sys);
			chk({47'h0, highLevelSelect}, {47'h0, k == 1 || k == 2}, "level select");
		end
		partner_i.stall <= 1'b1;
		partner_i.sendBase(1'b0);
		tog = 1'b1;
		for (int c = 0; c < 4; c++) begin
			expPage = {16'h2222, 16'h1111 + c[15:0], 4'h2, tog, codes[c]};
			apb(1'b1, 16'h0824, 16'h1111 + c[15:0]);
			apb(1'b1, 16'h0828, 16'h2222);
			apb(1'b1, 16'h0820, {5'h04, 11'h000} | {5'h00, codes[c]});
			waitTx(1'b1);
			chk(txPage, expPage, "offered page");
			apb(1'b0, 16'h0844, 16'h0000);
			chk(rd, {44'h0, c < 3, 1'b0, tog, 1'b1}, "status");
			partner_i.stall <= 1'b0;
			waitTx(1'b0);
			partner_i.stall <= 1'b1;
			chk(partner_i.lastPage, expPage, "taken page");
			tog = !tog;
		end
		partner_i.setPeer(16'h0000, 1'b1);
		apb(1'b0, 16'h0820, 16'h0000);
		chk(rd, 48'h6007, "acknowledge bit");
		partner_i.setPeer(16'h7800, 1'b0);
		apb(1'b1, 16'h0824, 16'h5555);
		apb(1'b1, 16'h0820, 16'h9abc);
		apb(1'b0, 16'h0814, 16'h0000);
		waitTx(1'b1);
		apb(1'b1, 16'h0840, 16'h0001);
		repeat (2) @(posedge clk_sys);
		chk({47'h0, txValid}, 48'h0, "offer dropped on autoneg reset");
		for (logic [15:0] j = 0; j < 4; j++) begin
			apb(1'b0, 16'h081c + (j << 2), 16'h0000);
			chk(rd, j == 1 ? 48'h2001 : 48'h0, "autoneg reset defaults");
		end
		apb(1'b0, 16'h0844, 16'h0000);
		chk(rd, 48'h8, "status after autoneg reset");
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		test_done();
	end
endmodule
